// [rtl/alem_match.sv]
// Single access control entry matcher for L4 ports, TCP flags and EtherType
`timescale 1ns/1ps
// ==========================================================
module alem_match (
  input  wire logic            CLK,       // Core clock, 25 MHz
  input  wire logic            RST_N,     // Asynchronous reset, active low
  input  wire logic            HDR_VALID, // Header fields valid this cycle
  input  wire alem_pkg::alem_hdr_t HDR,   // Parsed header fields
  input  wire alem_pkg::alem_cfg_t CFG,   // Entry configuration
  output logic                 RES_VALID, // Result valid, one cycle
  output logic                 HIT,       // Entry hit, with RES_VALID
  output logic                 CFG_ERR    // Illegal EtherType value programmed
);
  import alem_pkg::*;

  logic                     sport_ok;
  logic                     dport_ok;
  logic                     etype_ok;
  logic                     flags_ok;
  logic [ALEM_NUM_FLAGS-1:0] flag_ok;
  logic                     l4;
  logic                     cfg_err;
  logic                     hit_d;
  logic                     hit_q;
  logic                     valid_d;
  logic                     valid_q;
  logic                     err_d;
  logic                     err_q;

  // Port window test; a frame without an L4 header never matches a specific or range port filter
  function automatic logic port_match(input alem_port_mode_t mode,
                                      input logic [15:0] port,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi,
                                      input logic has_l4);
    logic r;
    r = 1'b0;
    unique case (mode)
      ALEM_PORT_ANY:      r = 1'b1;
      ALEM_PORT_SPECIFIC: r = has_l4 && (port == lo);
      ALEM_PORT_RANGE:    r = has_l4 && (port >= lo) && (port <= hi);
      default:            r = 1'b0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Port filters
  assign l4 = HDR.is_tcp | HDR.is_udp;
  always_comb begin
    sport_ok = port_match(CFG.sport_mode, HDR.src_port, CFG.sport_lo, CFG.sport_hi, l4);
    dport_ok = port_match(CFG.dport_mode, HDR.dst_port, CFG.dport_lo, CFG.dport_hi, l4);
  end

  // ==========================================================
  // TCP flag conditions, one per flag
  // zero/one/any per flag
  generate
    for (genvar i = 0; i < ALEM_NUM_FLAGS; i++) begin : g_flag
      always_comb begin
        unique case (CFG.flag_cond[i])
          // a set condition needs a TCP header
          ALEM_FLAG_ZERO: flag_ok[i] = HDR.is_tcp && !HDR.tcp_flags[i];
          ALEM_FLAG_ONE:  flag_ok[i] = HDR.is_tcp && HDR.tcp_flags[i];
          ALEM_FLAG_ANY:  flag_ok[i] = 1'b1;
          default:        flag_ok[i] = 1'b0;
        endcase
      end
    end
  endgenerate
  assign flags_ok = &flag_ok;

  // ==========================================================
  // EtherType filter
  always_comb begin
    // only for the EtherType frame category
    if (CFG.frame_type != ALEM_FT_ETYPE) begin
      etype_ok = 1'b1;
    end else if (CFG.etype_mode == ALEM_ETYPE_ANY) begin
      etype_ok = 1'b1;
    end else begin
      etype_ok = (HDR.ethertype == CFG.etype_value);
    end
  end

  // Flag a reserved or out-of-range value; matching itself is not altered
  // so software sees the mistake rather than a silent change of behaviour
  always_comb begin
    // excluded codes are a software error
    cfg_err = (CFG.frame_type == ALEM_FT_ETYPE) && (CFG.etype_mode == ALEM_ETYPE_SPECIFIC) &&
              ((CFG.etype_value < ALEM_ETYPE_MIN) || (CFG.etype_value > ALEM_ETYPE_MAX) ||
               (CFG.etype_value == ALEM_ETYPE_IPV4) || (CFG.etype_value == ALEM_ETYPE_ARP) ||
               (CFG.etype_value == ALEM_ETYPE_IPV6));
  end

  // ==========================================================
  // Result next values
  always_comb begin
    valid_d = HDR_VALID;
    hit_d   = HDR_VALID && sport_ok && dport_ok && flags_ok && etype_ok;
    err_d   = cfg_err;
  end

  // Result registers; one cycle latency keeps outputs glitch free
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hit_q   <= ALEM_HIT_RST;
      valid_q <= ALEM_VALID_RST;
      err_q   <= 1'b0;
    end else begin
      hit_q   <= hit_d;
      valid_q <= valid_d;
      err_q   <= err_d;
    end
  end

  assign HIT       = hit_q;
  assign RES_VALID = valid_q;
  assign CFG_ERR   = err_q;

  // ==========================================================
  // Checks
  chk_hit_valid: assert property (@(posedge CLK) disable iff (!RST_N)
    HIT |-> RES_VALID) else $error("hit without valid");
  chk_sport_spec: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.sport_mode == ALEM_PORT_SPECIFIC && HDR.src_port != CFG.sport_lo
    |=> !HIT) else $error("source specific mismatch hit");
  chk_sport_range: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.sport_mode == ALEM_PORT_RANGE &&
    (HDR.src_port < CFG.sport_lo || HDR.src_port > CFG.sport_hi) |=> !HIT)
    else $error("source out of range hit");
  chk_dport_spec: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.dport_mode == ALEM_PORT_SPECIFIC && HDR.dst_port != CFG.dport_lo
    |=> !HIT) else $error("destination specific mismatch hit");
  chk_dport_range: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.dport_mode == ALEM_PORT_RANGE &&
    (HDR.dst_port < CFG.dport_lo || HDR.dst_port > CFG.dport_hi) |=> !HIT)
    else $error("destination out of range hit");
  chk_fin_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.flag_cond[ALEM_FIN_BIT] == ALEM_FLAG_ZERO && HDR.tcp_flags[ALEM_FIN_BIT]
    |=> !HIT) else $error("FIN set but zero required");
  chk_syn_one: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.flag_cond[ALEM_SYN_BIT] == ALEM_FLAG_ONE && !HDR.tcp_flags[ALEM_SYN_BIT]
    |=> !HIT) else $error("SYN clear but one required");
  chk_flag_tcp: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && !HDR.is_tcp && CFG.flag_cond[ALEM_ACK_BIT] != ALEM_FLAG_ANY |=> !HIT)
    else $error("flag condition hit without TCP");
  chk_etype_spec: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.frame_type == ALEM_FT_ETYPE && CFG.etype_mode == ALEM_ETYPE_SPECIFIC &&
    HDR.ethertype != CFG.etype_value |=> !HIT) else $error("EtherType mismatch hit");
  chk_all_any: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.sport_mode == ALEM_PORT_ANY && CFG.dport_mode == ALEM_PORT_ANY &&
    CFG.flag_cond == {6{ALEM_FLAG_ANY}} && CFG.frame_type != ALEM_FT_ETYPE |=> HIT)
    else $error("all don't-care but no hit");

  // ==========================================================
  // Result timing and the remaining conditions
  // Result timing: one cycle after the header, nothing when idle
  chk_valid_next: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID |=> RES_VALID) else $error("request without result");
  chk_valid_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    !HDR_VALID |=> !RES_VALID && !HIT) else $error("result without request");

  // Filter branches that must let a frame pass
  chk_dport_any: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.dport_mode == ALEM_PORT_ANY |-> dport_ok)
    else $error("destination any blocked the frame");
  chk_etype_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.frame_type != ALEM_FT_ETYPE |-> etype_ok)
    else $error("EtherType filter applied to another frame type");
  chk_etype_any: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.frame_type == ALEM_FT_ETYPE && CFG.etype_mode == ALEM_ETYPE_ANY
    |-> etype_ok) else $error("EtherType any blocked the frame");
  chk_range_incl: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.sport_mode == ALEM_PORT_RANGE && l4 && CFG.sport_lo <= CFG.sport_hi &&
    (HDR.src_port == CFG.sport_lo || HDR.src_port == CFG.sport_hi) |-> sport_ok)
    else $error("range bound treated as outside");

  // Remaining flag conditions, each blocks a hit when violated; then the no-L4 port and CFG_ERR checks
  chk_rst_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.flag_cond[ALEM_RST_BIT] == ALEM_FLAG_ZERO && HDR.tcp_flags[ALEM_RST_BIT]
    |=> !HIT) else $error("RST set but zero required");
  chk_psh_one: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.flag_cond[ALEM_PSH_BIT] == ALEM_FLAG_ONE && !HDR.tcp_flags[ALEM_PSH_BIT]
    |=> !HIT) else $error("PSH clear but one required");
  chk_ack_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.flag_cond[ALEM_ACK_BIT] == ALEM_FLAG_ZERO && HDR.tcp_flags[ALEM_ACK_BIT]
    |=> !HIT) else $error("ACK set but zero required");
  chk_urg_one: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && CFG.flag_cond[ALEM_URG_BIT] == ALEM_FLAG_ONE && !HDR.tcp_flags[ALEM_URG_BIT]
    |=> !HIT) else $error("URG clear but one required");
  chk_no_l4_port: assert property (@(posedge CLK) disable iff (!RST_N)
    HDR_VALID && !HDR.is_tcp && !HDR.is_udp && CFG.dport_mode == ALEM_PORT_RANGE
    |=> !HIT) else $error("port filter hit without L4 header");
  chk_cfg_err: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG.frame_type == ALEM_FT_ETYPE && CFG.etype_mode == ALEM_ETYPE_SPECIFIC &&
    CFG.etype_value == ALEM_ETYPE_IPV6 |=> CFG_ERR) else $error("excluded EtherType not flagged");
endmodule

// [inc/alem_pkg.sv]
// Package of types and constants for the access control entry L4/EtherType matcher
package alem_pkg;

  // Port filter modes
  typedef enum logic [1:0] {
    ALEM_PORT_ANY      = 2'h0,
    ALEM_PORT_SPECIFIC = 2'h1,
    ALEM_PORT_RANGE    = 2'h2
  } alem_port_mode_t;

  // Three-way TCP flag condition
  typedef enum logic [1:0] {
    ALEM_FLAG_ZERO = 2'h0,
    ALEM_FLAG_ONE  = 2'h1,
    ALEM_FLAG_ANY  = 2'h2
  } alem_flag_cond_t;

  // EtherType filter modes
  typedef enum logic [0:0] {
    ALEM_ETYPE_ANY      = 1'h0,
    ALEM_ETYPE_SPECIFIC = 1'h1
  } alem_etype_mode_t;

  // Entry frame type category; only ETYPE enables the EtherType filter
  typedef enum logic [1:0] {
    ALEM_FT_ANY   = 2'h0,
    ALEM_FT_ETYPE = 2'h1,
    ALEM_FT_ARP   = 2'h2,
    ALEM_FT_IPV4  = 2'h3
  } alem_frame_type_t;

  // TCP flag positions in the flag vector
  localparam int unsigned ALEM_FIN_BIT = 0;
  localparam int unsigned ALEM_SYN_BIT = 1;
  localparam int unsigned ALEM_RST_BIT = 2;
  localparam int unsigned ALEM_PSH_BIT = 3;
  localparam int unsigned ALEM_ACK_BIT = 4;
  localparam int unsigned ALEM_URG_BIT = 5;
  localparam int unsigned ALEM_NUM_FLAGS = 6;

  // Legal EtherType bounds and excluded codes for the specific value
  localparam logic [15:0] ALEM_ETYPE_MIN  = 16'h0600;
  localparam logic [15:0] ALEM_ETYPE_MAX  = 16'hFFFF;
  localparam logic [15:0] ALEM_ETYPE_IPV4 = 16'h0800;
  localparam logic [15:0] ALEM_ETYPE_ARP  = 16'h0806;
  localparam logic [15:0] ALEM_ETYPE_IPV6 = 16'h86DD;

  // Reset values of the result flops
  localparam logic ALEM_HIT_RST   = 1'b0;
  localparam logic ALEM_VALID_RST = 1'b0;

  // Header fields from the ingress parser
  typedef struct packed {
    logic        is_tcp;
    logic        is_udp;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [5:0]  tcp_flags;
    logic [15:0] ethertype;
  } alem_hdr_t;

  // Entry configuration from management
  typedef struct packed {
    alem_frame_type_t      frame_type;
    alem_port_mode_t       sport_mode;
    logic [15:0]           sport_lo;
    logic [15:0]           sport_hi;
    alem_port_mode_t       dport_mode;
    logic [15:0]           dport_lo;
    logic [15:0]           dport_hi;
    alem_flag_cond_t [5:0] flag_cond;
    alem_etype_mode_t      etype_mode;
    logic [15:0]           etype_value;
  } alem_cfg_t;

endpackage

// [bench/alem_parser_model.sv]
// Ingress parser model presenting header fields to the matcher
`timescale 1ns/1ps
module alem_parser_model (
  input  wire logic                CLK,       // Core clock
  input  wire logic                RST_N,     // Reset, active low
  input  wire logic                go,        // Present a header this cycle
  input  wire alem_pkg::alem_hdr_t go_hdr,    // Header to present
  output logic                     hdr_valid, // Header valid strobe
  output alem_pkg::alem_hdr_t      hdr        // Header fields
);
  import alem_pkg::*;
  alem_hdr_t last_q;
  // Idle cycles show the inverse of the last header so stale data never matches
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) last_q <= '0;
    else if (go) last_q <= go_hdr;
  end
  assign hdr_valid = go;
  assign hdr       = go ? go_hdr : ~last_q;
endmodule

// [bench/alem_match_bench.sv]
// Self-checking bench for the access control entry matcher
`timescale 1ns/1ps
module alem_match_bench;
  import alem_pkg::*;
  logic        CLK = 1'b0, RST_N = 1'b0, go = 1'b0, HDR_VALID, RES_VALID, HIT, CFG_ERR;
  alem_hdr_t   go_hdr = '0, HDR;
  alem_cfg_t   CFG = '0;
  logic        exp_q[$];
  logic        err_exp = 1'b0;
  int          num_errors = 0, cmp_count = 0;
  logic [31:0] seed = 32'h43;
  logic [15:0] etab[6] = '{16'h05FF, 16'h0600, 16'h0800, 16'h0806, 16'h86DD, 16'hFFFF};

  initial forever #20 CLK = ~CLK;
  alem_parser_model u_parser (.CLK(CLK), .RST_N(RST_N), .go(go), .go_hdr(go_hdr),
                              .hdr_valid(HDR_VALID), .hdr(HDR));
  alem_match dut (.CLK(CLK), .RST_N(RST_N), .HDR_VALID(HDR_VALID), .HDR(HDR), .CFG(CFG),
                  .RES_VALID(RES_VALID), .HIT(HIT), .CFG_ERR(CFG_ERR));

  // ==========================================================
  // Reference model
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic port_ok(alem_port_mode_t m, logic [15:0] p, lo, hi, logic l4);
    case (m)
      ALEM_PORT_ANY:      return 1'b1;
      ALEM_PORT_SPECIFIC: return l4 && p == lo;
      ALEM_PORT_RANGE:    return l4 && p >= lo && p <= hi;
      default:            return 1'b0;
    endcase
  endfunction
  function automatic logic exp_hit(alem_hdr_t h, alem_cfg_t c);
    logic ok;
    ok = port_ok(c.sport_mode, h.src_port, c.sport_lo, c.sport_hi, h.is_tcp | h.is_udp);
    ok &= port_ok(c.dport_mode, h.dst_port, c.dport_lo, c.dport_hi, h.is_tcp | h.is_udp);
    // flag conditions; code 3 never matches
    for (int i = 0; i < ALEM_NUM_FLAGS; i++) begin
      if (c.flag_cond[i] == ALEM_FLAG_ZERO) ok &= h.is_tcp && !h.tcp_flags[i];
      else if (c.flag_cond[i] == ALEM_FLAG_ONE) ok &= h.is_tcp && h.tcp_flags[i];
      else if (c.flag_cond[i] != ALEM_FLAG_ANY) ok = 1'b0;
    end
    if (c.frame_type == ALEM_FT_ETYPE && c.etype_mode == ALEM_ETYPE_SPECIFIC) begin
      ok &= h.ethertype == c.etype_value;
    end
    return ok;
  endfunction
  function automatic logic err_of(alem_cfg_t c);
    return c.frame_type == ALEM_FT_ETYPE && c.etype_mode == ALEM_ETYPE_SPECIFIC &&
      (c.etype_value < ALEM_ETYPE_MIN ||
       c.etype_value inside {ALEM_ETYPE_IPV4, ALEM_ETYPE_ARP, ALEM_ETYPE_IPV6});
  endfunction
  // Mostly bounds and their neighbours, where range slips show up
  function automatic logic [15:0] pick(logic [15:0] lo, hi);
    case (rnd() % 8)
      0, 1, 2: return lo;
      3, 4:    return hi;
      5:       return lo - 16'h1;
      6:       return hi + 16'h1;
      default: return 16'(rnd());
    endcase
  endfunction
  task automatic check(string name, logic seen, logic exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // Stimulus: random entries and headers, gaps and back-to-back
  initial begin
    alem_hdr_t h;
    alem_cfg_t c;
    logic      g;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    for (int n = 0; n < 3000; n++) begin
      @(posedge CLK);
      c.frame_type = alem_frame_type_t'(2'(rnd()));
      // Mode code 3 never matches; drawn now and then so that branch is reached
      c.sport_mode = alem_port_mode_t'((rnd() % 16 == 0) ? 2'h3 : 2'(rnd() % 3));
      c.dport_mode = alem_port_mode_t'((rnd() % 16 == 0) ? 2'h3 : 2'(rnd() % 3));
      c.sport_lo = 16'(rnd());
      c.sport_hi = c.sport_lo + 16'(rnd() % 4);
      c.dport_lo = 16'(rnd());
      c.dport_hi = c.dport_lo + 16'(rnd() % 4);
      c.etype_mode = alem_etype_mode_t'(1'(rnd()));
      // excluded codes exercised, CFG_ERR must report them
      c.etype_value = (rnd() % 2) ? etab[rnd() % 6] : 16'(rnd());
      h.is_tcp = (rnd() % 8) != 0;
      h.is_udp = !h.is_tcp && rnd() % 2;
      h.src_port = pick(c.sport_lo, c.sport_hi);
      h.dst_port = pick(c.dport_lo, c.dport_hi);
      h.ethertype = (rnd() % 4) ? c.etype_value : 16'(rnd());
      for (int i = 0; i < ALEM_NUM_FLAGS; i++) begin
        c.flag_cond[i] = alem_flag_cond_t'((rnd() % 16 == 0) ? 2'h3 : 2'(rnd() % 3));
        h.tcp_flags[i] = c.flag_cond[i][0] ^ (rnd() % 6 == 0);
      end
      // Now and then an entry with both ports and all flags open, so the all-pass path is reached
      if (rnd() % 16 == 0) begin
        c.sport_mode = ALEM_PORT_ANY;
        c.dport_mode = ALEM_PORT_ANY;
        for (int i = 0; i < ALEM_NUM_FLAGS; i++) c.flag_cond[i] = ALEM_FLAG_ANY;
      end
      g = (rnd() % 4) != 0;
      go <= g;
      go_hdr <= h;
      CFG <= c;
      if (g) exp_q.push_back(exp_hit(h, c));
    end
    @(posedge CLK);
    go <= 1'b0;
    repeat (3) @(posedge CLK);
    check("pending_results", exp_q.size() == 0, 1'b1);
    report_and_stop();
  end

  // Monitor: one result per request, matched in request order
  initial forever begin
    @(posedge CLK);
    #1;
    if (RES_VALID === 1'b1 && exp_q.size() == 0) check("RES_VALID", 1'b1, 1'b0);
    else if (RES_VALID === 1'b1) check("HIT", HIT, exp_q.pop_front());
    else begin
      check("RES_VALID_idle", RES_VALID, 1'b0);
      check("HIT_idle", HIT, 1'b0);
    end
    check("CFG_ERR", CFG_ERR, err_exp);
    err_exp = err_of(CFG);
  end

  initial begin
    repeat (4000) @(posedge CLK);
    num_errors++;
    report_and_stop();
  end
endmodule
